/* src/gdc_cfg.svh */
`ifndef GDC_CFG_SVH
`define GDC_CFG_SVH

// clock and reference timing, in picoseconds
`define GDC_PCLK_PS     5000
`define GDC_OSC_PS      100000
`define GDC_OSC_DIV     (`GDC_OSC_PS / `GDC_PCLK_PS)
`define GDC_OUT_DIV     10
`define GDC_STRETCH_PS  50000
`define GDC_STRETCH_CYC ((`GDC_STRETCH_PS + `GDC_PCLK_PS - 1) / `GDC_PCLK_PS)
`define GDC_SCAN_PS     1000000
`define GDC_SCAN_CYC    (`GDC_SCAN_PS / `GDC_PCLK_PS)

// register byte offsets
`define GDC_CTRL_OFS    8'h00
`define GDC_STAT_OFS    8'h04
`define GDC_COUNT_OFS   8'h08

// control field positions and reset value
`define GDC_F_FUNC      3:0
`define GDC_F_TBCODE    6:4
`define GDC_F_FORCE     7
`define GDC_F_SCALE     9:8
`define GDC_CTRL_W      10
`define GDC_CTRL_RST    10'h000

`endif

/* src/gdc_pkg.sv */
package gdc_pkg;
    typedef enum logic [2:0] {
        MUX_A, MUX_B, MUX_GATED_REFERENCE_PULSES, MUX_C, MUX_DVM, MUX_TBO, MUX_OSC
    } gdc_mux_t;
    typedef enum logic [1:0] {TB_OSC, TB_A, TB_B} gdc_tbsel_t;
    typedef enum logic [2:0] {ST_RESET, ST_GATE, ST_XFER, ST_SHOW} gdc_state_t;
    typedef struct packed {
        gdc_mux_t   in_sel;
        gdc_tbsel_t tb_sel;
        logic       en_timed;
        logic       en_interval;
        logic       en_total;
    } gdc_decode_t;
    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic gated_reference_pulses;
        logic voltmeter_pulses;
    } gdc_pulses_t;
    typedef struct packed {
        logic [3:0] data;
        logic       valid;
    } gdc_digit_t;
endpackage : gdc_pkg

/* src/gdc_decade.sv */
`timescale 1ns/1ps
module gdc_decade (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clear,
    input  wire logic       step,
    output logic      [3:0] digit,
    output logic            carry
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            digit <= 4'h0;
        end else if (clear) begin
            digit <= 4'h0;
        end else if (step) begin
            digit <= (digit == 4'h9) ? 4'h0 : digit + 4'h1;
        end
    end

    assign carry = step && (digit == 4'h9);
endmodule : gdc_decade

/* src/gdc_core.sv */
`timescale 1ns/1ps
`include "gdc_cfg.svh"
module gdc_core #(
    parameter int TB_DECADES = 8
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic          [7:0] paddr,
    input  wire logic         [31:0] pwdata,
    output logic              [31:0] prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire gdc_pkg::gdc_pulses_t pulses,
    input  wire gdc_pkg::gdc_digit_t chan_c_digit,
    input  wire logic                ext_ref_present,
    input  wire logic                ext_ref_pulses,
    input  wire logic                interval_gate_source_n,
    input  wire logic                totalize_gate_source_n,
    input  wire logic                start_gate_source_n,
    input  wire logic                sample_rate_tick,
    output logic                     ref_1mhz_out,
    output logic               [3:0] data_bus_out,
    output logic                     data_bus_oe_n,
    output logic               [6:0] segments,
    output logic               [9:0] digit_sel,
    output logic                     gate_status,
    output logic                     remote_gate_p,
    output logic                     remote_gate_n,
    output logic                     overflow,
    output logic                     inhibit,
    output logic                     count_reset,
    output logic                     transfer
);
    import gdc_pkg::*;

    localparam logic [4:0] OSC_LAST  = 5'(`GDC_OSC_DIV - 1);
    localparam logic [2:0] HALF_LAST = 3'(`GDC_OUT_DIV / 2 - 1);
    localparam logic [3:0] STRETCH   = 4'(`GDC_STRETCH_CYC);
    localparam logic [7:0] SCAN_LAST = 8'(`GDC_SCAN_CYC - 1);

    function automatic gdc_decode_t decode_func(input logic [3:0] f);
        gdc_decode_t d;
        d = '{in_sel: MUX_A, tb_sel: TB_OSC, en_timed: 1'b1,
              en_interval: 1'b0, en_total: 1'b0};
        case (f)
            4'h1: d.in_sel = MUX_B;
            4'h2: d.in_sel = MUX_C;
            4'h3: begin
                d.in_sel = MUX_OSC;
                d.tb_sel = TB_A;
            end
            4'h4: begin
                d.in_sel      = MUX_OSC;
                d.en_timed    = 1'b0;
                d.en_interval = 1'b1;
            end
            4'h5: begin
                d.en_timed = 1'b0;
                d.en_total = 1'b1;
            end
            4'h6: d.tb_sel = TB_B;
            4'h7: d.in_sel = MUX_DVM;
            4'h8: d.in_sel = MUX_OSC;
            4'h9: begin
                d.in_sel   = MUX_TBO;
                d.tb_sel   = TB_A;
                d.en_timed = 1'b0;
                d.en_total = 1'b1;
            end
            4'ha: begin
                d.in_sel      = MUX_GATED_REFERENCE_PULSES;
                d.en_timed    = 1'b0;
                d.en_interval = 1'b1;
            end
            default: ;
        endcase
        return d;
    endfunction : decode_func

    function automatic logic [15:0] ref_step(input logic [15:0] per,
                                             input logic [1:0]  sc);
        case (sc)
            2'h0:    return per;
            2'h1:    return per >> 1;
            default: return 16'(per / 16'd10);
        endcase
    endfunction : ref_step

    function automatic logic [6:0] seg7(input logic [3:0] v);
        case (v)
            4'h0:    return 7'h3f;
            4'h1:    return 7'h06;
            4'h2:    return 7'h5b;
            4'h3:    return 7'h4f;
            4'h4:    return 7'h66;
            4'h5:    return 7'h6d;
            4'h6:    return 7'h7d;
            4'h7:    return 7'h07;
            4'h8:    return 7'h7f;
            4'h9:    return 7'h6f;
            default: return 7'h00;
        endcase
    endfunction : seg7

    logic [`GDC_CTRL_W-1:0] ctrl;
    gdc_state_t       state;
    gdc_decode_t      dec;
    logic [2:0]       tb_code;
    logic             force_gate_open;
    logic             input_select_0, input_select_1, input_select_2;
    logic [4:0]       osc_cnt;
    logic             int_tick, ext_tick, reference_pulses;
    logic [2:0]       half_cnt;
    logic [15:0]      per_cnt, per, phase, step;
    logic             tb_tick, divided_timebase_output;
    logic [TB_DECADES-1:0] tb_carry;
    logic             shape_ff, sync_ff, main_gate_ff, tb_done;
    logic             timed_gate_source_n, gate, gate_q, sel_pulse;
    logic             cnt_in;
    logic [3:0]       stretch_cnt;
    logic             bin_ff;
    logic [2:0]       quin;
    logic [7:0]       cnt_carry;
    logic [31:0]      chain, latched;
    logic [7:0]       scan_cnt;
    logic             scan_tick;
    logic [3:0]       digit_addr, digit_val;
    logic             nz_seen, show_blank;

    // register bus: zero-wait slave, read data loaded in setup phase, write data captured in access phase
    assign pready = 1'b1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `GDC_CTRL_RST;
        end else if (psel && penable && pwrite &&
                     paddr == `GDC_CTRL_OFS) begin
            ctrl <= pwdata[`GDC_CTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= 1'b0;
            if (paddr == `GDC_CTRL_OFS) begin
                prdata <= {22'h0, ctrl};
            end else if (paddr == `GDC_STAT_OFS) begin
                prdata <= {26'h0, ext_ref_present, gate_status,
                           overflow, state};
            end else if (paddr == `GDC_COUNT_OFS) begin
                prdata <= latched;
            end else begin
                prdata  <= 32'h0;
                pslverr <= 1'b1;
            end
        end
    end

    assign dec             = decode_func(ctrl[`GDC_F_FUNC]);
    assign tb_code         = ctrl[`GDC_F_TBCODE];
    assign force_gate_open = ctrl[`GDC_F_FORCE];
    assign {input_select_2, input_select_1, input_select_0} = dec.in_sel;

    // internal 10 MHz tick and the 1 MHz square wave beside it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt  <= 5'h0;
            int_tick <= 1'b0;
        end else begin
            int_tick <= (osc_cnt == OSC_LAST);
            osc_cnt  <= (osc_cnt == OSC_LAST) ? 5'h0 : osc_cnt + 5'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_cnt     <= 3'h0;
            ref_1mhz_out <= 1'b0;
        end else if (int_tick) begin
            half_cnt <= (half_cnt == HALF_LAST) ? 3'h0 : half_cnt + 3'h1;
            if (half_cnt == HALF_LAST) begin
                ref_1mhz_out <= !ref_1mhz_out;
            end
        end
    end

    // external reference: measure its period, fill in one, two or ten ticks per period by scale
    assign step = ref_step(per, ctrl[`GDC_F_SCALE]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt <= 16'h0;
            per     <= 16'h0;
        end else if (ext_ref_pulses) begin
            per     <= per_cnt + 16'h1;
            per_cnt <= 16'h0;
        end else if (per_cnt != 16'hffff) begin
            per_cnt <= per_cnt + 16'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase    <= 16'h0;
            ext_tick <= 1'b0;
        end else if (ext_ref_pulses || phase + 16'h1 >= step) begin
            phase    <= 16'h0;
            ext_tick <= 1'b1;
        end else begin
            phase    <= phase + 16'h1;
            ext_tick <= 1'b0;
        end
    end

    assign reference_pulses = ext_ref_present ? ext_tick : int_tick;

    always_comb begin
        case (dec.tb_sel)
            TB_A:    tb_tick = pulses.a;
            TB_B:    tb_tick = pulses.b;
            default: tb_tick = reference_pulses;
        endcase
    end

    // time base divider; tb_code N picks the carry of decade N-1, tb_code 0 the undivided tb_tick
    genvar i;
    for (i = 0; i < TB_DECADES; i++) begin : g_tb
        gdc_decade u_tb (
            .pclk    (pclk),
            .presetn (presetn),
            .clear   (count_reset),
            .step    (i == 0 ? tb_tick : tb_carry[i > 0 ? i - 1 : 0]),
            .digit   (),
            .carry   (tb_carry[i])
        );
    end

    assign divided_timebase_output = (tb_code == 3'h0) ? tb_tick :
                                     tb_carry[tb_code - 3'h1];

    // gate spans one divided period; both outputs run together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shape_ff <= 1'b0;
            tb_done  <= 1'b0;
        end else if (count_reset) begin
            shape_ff <= 1'b0;
            tb_done  <= 1'b0;
        end else if (divided_timebase_output && state == ST_GATE &&
                     !tb_done) begin
            shape_ff <= !shape_ff;
            tb_done  <= shape_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_ff      <= 1'b0;
            main_gate_ff <= 1'b0;
        end else if (count_reset) begin
            sync_ff      <= 1'b0;
            main_gate_ff <= 1'b0;
        end else if (tb_tick) begin
            sync_ff      <= shape_ff;
            main_gate_ff <= sync_ff;
        end
    end

    assign timed_gate_source_n = !main_gate_ff;

    // hold-open wins; other sources only through their enables
    assign gate = (state == ST_GATE) && (force_gate_open
        || (dec.en_interval && !interval_gate_source_n)
        || (dec.en_timed && !timed_gate_source_n)
        || (dec.en_total && !totalize_gate_source_n
            && !start_gate_source_n));

    always_comb begin
        case (gdc_mux_t'({input_select_2, input_select_1,
                          input_select_0}))
            MUX_A:    sel_pulse = pulses.a;
            MUX_B:    sel_pulse = pulses.b;
            MUX_GATED_REFERENCE_PULSES: sel_pulse = pulses.gated_reference_pulses;
            MUX_C:    sel_pulse = pulses.c;
            MUX_DVM:  sel_pulse = pulses.voltmeter_pulses;
            MUX_TBO:  sel_pulse = divided_timebase_output;
            MUX_OSC:  sel_pulse = reference_pulses;
            default:  sel_pulse = 1'b0;
        endcase
    end

    assign cnt_in = sel_pulse && gate;

    // rc stretch stand-in so the lamp sees short gates; the sequencer uses the raw gate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_q        <= 1'b0;
            stretch_cnt   <= 4'h0;
            gate_status   <= 1'b0;
            remote_gate_p <= 1'b0;
            remote_gate_n <= 1'b1;
        end else begin
            gate_q        <= gate;
            stretch_cnt   <= gate ? STRETCH :
                             (stretch_cnt != 4'h0) ? stretch_cnt - 4'h1 :
                             4'h0;
            gate_status   <= gate || (stretch_cnt != 4'h0);
            remote_gate_p <= gate;
            remote_gate_n <= !gate;
        end
    end

    // first decade: binary then quinary, bcd = 2*quin + bin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bin_ff <= 1'b0;
            quin   <= 3'h0;
        end else if (count_reset) begin
            bin_ff <= 1'b0;
            quin   <= 3'h0;
        end else if (cnt_in) begin
            bin_ff <= !bin_ff;
            if (bin_ff) begin
                quin <= (quin == 3'h4) ? 3'h0 : quin + 3'h1;
            end
        end
    end

    assign chain[3:0]   = {quin, bin_ff};
    assign cnt_carry[0] = cnt_in && bin_ff && (quin == 3'h4);

    for (i = 1; i < 8; i++) begin : g_cnt
        gdc_decade u_cnt (
            .pclk    (pclk),
            .presetn (presetn),
            .clear   (count_reset),
            .step    (cnt_carry[i - 1]),
            .digit   (chain[4*i +: 4]),
            .carry   (cnt_carry[i])
        );
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow <= 1'b0;
        end else if (count_reset) begin
            overflow <= 1'b0;
        end else if (cnt_carry[7]) begin
            overflow <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched <= 32'h0;
        end else if (transfer) begin
            latched <= chain;
        end
    end

    // measurement sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_RESET;
        end else begin
            case (state)
                ST_RESET: state <= ST_GATE;
                ST_GATE: begin
                    if ((gate_q && !gate) ||
                        (force_gate_open && sample_rate_tick)) begin
                        state <= ST_XFER;
                    end
                end
                ST_XFER: state <= ST_SHOW;
                ST_SHOW: begin
                    if (sample_rate_tick) begin
                        state <= ST_RESET;
                    end
                end
                default: state <= ST_RESET;
            endcase
        end
    end

    assign count_reset = (state == ST_RESET);
    assign transfer    = (state == ST_XFER);
    assign inhibit     = (state == ST_SHOW);

    // display scan, most significant digit first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_cnt  <= 8'h0;
            scan_tick <= 1'b0;
        end else begin
            scan_tick <= (scan_cnt == SCAN_LAST);
            scan_cnt  <= (scan_cnt == SCAN_LAST) ? 8'h0 : scan_cnt + 8'h1;
        end
    end

    gdc_decade u_scan (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (1'b0),
        .step    (scan_tick),
        .digit   (digit_addr),
        .carry   ()
    );

    // address 8 leaves the bus to the channel C module
    assign digit_val = (digit_addr < 4'h8) ?
                       latched[4*(3'h7 - digit_addr[2:0]) +: 4] :
                       chan_c_digit.data;
    // the last chain digit always shows so a zero count reads 0
    assign show_blank = (digit_addr == 4'h9) ||
        (digit_addr == 4'h8 && !chan_c_digit.valid) ||
        (digit_addr < 4'h7 && digit_val == 4'h0 &&
         (digit_addr == 4'h0 || !nz_seen));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nz_seen <= 1'b0;
        end else if (digit_addr == 4'h0) begin
            nz_seen <= (digit_val != 4'h0);
        end else if (digit_val != 4'h0 && digit_addr < 4'h8) begin
            nz_seen <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_bus_out  <= 4'h0;
            data_bus_oe_n <= 1'b1;
            segments      <= 7'h00;
            digit_sel     <= 10'h001;
        end else begin
            data_bus_out  <= (digit_addr < 4'h8) ? digit_val : 4'h0;
            data_bus_oe_n <= !(digit_addr < 4'h8);
            segments      <= show_blank ? 7'h00 : seg7(digit_val);
            digit_sel     <= 10'h001 << digit_addr;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_gate_close;
        state == ST_GATE && gate_q && !gate;
    endsequence

    sequence s_xfer_then_show;
        transfer ##1 inhibit;
    endsequence

    chk_close_xfer: assert property (
        s_gate_close |=> s_xfer_then_show)
        else $error("gate close did not start transfer");
    chk_gate_holds: assert property (
        !gate && !count_reset |=> $stable(chain))
        else $error("chain moved while gate closed");
    chk_force_open: assert property (
        force_gate_open && state == ST_GATE
        |=> remote_gate_p && !remote_gate_n)
        else $error("hold-open did not open gate");
    chk_ovf_sticky: assert property (
        overflow && !count_reset |=> overflow)
        else $error("overflow dropped before reset");
    chk_reset_clear: assert property (
        count_reset |=> chain == 32'h0 && !main_gate_ff && !shape_ff)
        else $error("reset left counts standing");
    chk_xfer_latch: assert property (
        transfer |=> latched == $past(chain))
        else $error("transfer did not latch count");
    chk_mgff_tick: assert property (
        !tb_tick && !count_reset |=> $stable(main_gate_ff))
        else $error("main gate moved off a tick");
    chk_gate_stretch: assert property (
        $fell(gate_q) |-> gate_status [*8])
        else $error("gate status not stretched");
    chk_digit_onehot: assert property (
        $onehot(digit_sel))
        else $error("digit select not one-hot");
    chk_scan_step: assert property (
        scan_tick |=> digit_addr == (($past(digit_addr) == 4'h9) ?
                      4'h0 : $past(digit_addr) + 4'h1))
        else $error("scan counter stepped wrongly");
endmodule : gdc_core

/* tb/gdc_input_model.sv */
`timescale 1ns/1ps
module gdc_input_model
    import gdc_pkg::*;
(
    input  wire logic           pclk,
    input  wire logic           run,
    input  wire logic     [3:0] gap,
    output gdc_pkg::gdc_pulses_t pulses,
    output gdc_pkg::gdc_digit_t  chan_c_digit,
    output logic          [7:0] n_sent
);
    logic [3:0] tmr = '0;
    // channel c offers a fixed ninth digit
    assign chan_c_digit = '{data: 4'h5, valid: 1'b1};
    initial pulses = '0;
    initial n_sent = '0;
    // one-cycle pulses, gap+1 cycles apart, so none merge while gap is nonzero
    always @(posedge pclk) begin
        pulses.a <= 1'b0;
        if (run && tmr == 4'h0) begin
            pulses.a <= 1'b1;
            n_sent <= n_sent + 8'h01;
        end
        tmr <= (run && tmr != 4'h0) ? tmr - 4'h1 : gap;
    end
endmodule : gdc_input_model

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import gdc_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        run = 0, tick = 0, pready, pslverr, err, r1m, gst;
    logic        oe_n, rgp, rgn, ovf, inh, crst, xfer;
    logic        ext = 0, eref = 0;
    logic  [3:0] gap = 4'h3, dbus;
    logic  [6:0] seg;
    logic  [7:0] paddr = '0, n_sent;
    logic  [9:0] dsel;
    logic [31:0] pwdata = '0, prdata, rd;
    gdc_pulses_t pulses;
    gdc_digit_t  cdig;
    int          fail_count = 0, n_tests = 0, i, ecnt = 0;
    initial forever #2.5 pclk = ~pclk;
    // external reference at 5 MHz, one pulse per 40 cycles once enabled
    always @(posedge pclk) begin
        ecnt <= (ecnt == 39) ? 0 : ecnt + 1;
        eref <= ext && ecnt == 39;
    end
    gdc_input_model PM (.pclk(pclk), .run(run), .gap(gap), .pulses(pulses),
        .chan_c_digit(cdig), .n_sent(n_sent));
    gdc_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pulses(pulses), .chan_c_digit(cdig), .ext_ref_present(ext),
        .ext_ref_pulses(eref), .interval_gate_source_n(1'b1),
        .totalize_gate_source_n(1'b1), .start_gate_source_n(1'b1),
        .sample_rate_tick(tick), .ref_1mhz_out(r1m), .data_bus_out(dbus),
        .data_bus_oe_n(oe_n), .segments(seg), .digit_sel(dsel),
        .gate_status(gst), .remote_gate_p(rgp), .remote_gate_n(rgn),
        .overflow(ovf), .inhibit(inh), .count_reset(crst), .transfer(xfer));
    task chk(input bit ok, input string m);
        n_tests++;
        if (!ok) begin
            fail_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task pulse_tick;
        @(posedge pclk);
        tick <= 1;
        @(posedge pclk);
        tick <= 0;
    endtask : pulse_tick
    task wait_xfer(input int lim);
        for (i = 0; i < lim && xfer !== 1'b1; i++) #5;
        chk(xfer === 1'b1, "no transfer");
    endtask : wait_xfer
    task wait_sel(input logic [9:0] v);
        for (i = 0; i < 2500 && dsel !== v; i++) #5;
        chk(dsel === v && $onehot(dsel), "digit select");
    endtask : wait_sel
    task t_forced;
        apb(1, 8'h00, 32'h80);
        for (i = 0; i < 200 && gst !== 1'b1; i++) @(posedge pclk);
        repeat (10) @(posedge pclk);
        chk(gst === 1'b1, "forced gate");
        chk(rgp === 1'b1 && rgn === 1'b0, "remote gate pair");
        run <= 1;
        wait (n_sent == 8'd123);
        @(posedge pclk);
        run <= 0;
        repeat (10) @(posedge pclk);
        pulse_tick();
        #1 wait_xfer(20);
        #5 chk(inh === 1'b1, "inhibit after transfer");
        @(posedge pclk);
        run <= 1;
        repeat (40) @(posedge pclk);
        run <= 0;
        apb(0, 8'h08, 32'h0);
        chk(rd === 32'h123, "count");
        apb(0, 8'h04, 32'h0);
        chk(rd === 32'h3 && ovf === 1'b0, "status");
    endtask : t_forced
    task t_display;
        #1;
        wait_sel(10'h080);
        chk(seg === 7'h4f && dbus === 4'h3, "digit 0");
        chk(oe_n === 1'b0, "bus driven");
        wait_sel(10'h100);
        chk(oe_n === 1'b1, "bus released");
        chk(seg === 7'h6d, "channel c digit");
        wait_sel(10'h001);
        chk(seg === 7'h00, "leading zero");
        wait_sel(10'h010);
        chk(seg === 7'h00, "inner leading zero");
        wait_sel(10'h020);
        chk(seg === 7'h06, "inner digit");
    endtask : t_display
    task t_timed(input logic [31:0] c, input logic [31:0] lo,
                 input logic [31:0] hi);
        apb(1, 8'h00, c);
        gap <= 4'h1;
        pulse_tick();
        run <= 1;
        #1 wait_xfer(3000);
        @(posedge pclk);
        run <= 0;
        apb(0, 8'h08, 32'h0);
        chk(rd >= lo && rd <= hi, "timed count");
    endtask : t_timed
    // period is learnt from two pulses before the gate may start
    task t_ext;
        ext <= 1;
        repeat (130) @(posedge pclk);
        t_timed(32'h0, 32'h19, 32'h21);
        t_timed(32'h100, 32'h9, 32'h11);
    endtask : t_ext
    task t_ref;
        @(posedge r1m);
        for (i = 0; i < 400; i++) begin
            @(posedge pclk);
            #1 if (r1m === 1'b0) break;
        end
        chk(i == 99, "ref high half");
    endtask : t_ref
    task finish_test;
        $display("fails %0d checks %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    initial begin
        #200000;
        fail_count++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge pclk);
        chk(crst === 1'b1 && dsel === 10'h001 && oe_n === 1'b1, "reset");
        presetn <= 1;
        apb(0, 8'h00, 32'h0);
        chk(rd === 32'h0 && err === 1'b0, "ctrl reset");
        apb(1, 8'h40, 32'h5);
        chk(err === 1'b1, "unmapped");
        t_forced();
        t_display();
        t_timed(32'h0, 32'h9, 32'h11);
        t_timed(32'h18, 32'h10, 32'h10);
        t_ext();
        t_ref();
        finish_test();
    end
endmodule : tb_top
